//--- hqc_pkg.sv
// Purpose: shared constants of the host queue command and control block
// Assumes: byte addresses on the host bus, 16-bit register words
// Notes: register words sit at even byte addresses
package hqc_pkg;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [10:0] RX_FRAME_BYTE_COUNT_OFF = 11'h17e;
  localparam logic [10:0] TX_QUEUE_COMMAND_OFF = 11'h180;
  localparam logic [10:0] RX_QUEUE_COMMAND_OFF = 11'h182;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int BYTE_COUNT_W = 12;
  localparam int TXQ_MANUAL_ENQUEUE_BIT = 0;
  localparam int TXQ_SPACE_MONITOR_BIT = 1;
  localparam int RXQ_RELEASE_ERROR_BIT = 0;
  localparam int RXQ_DMA_ACCESS_BIT = 3;
  localparam int RXQ_AUTO_DEQUEUE_BIT = 4;
  localparam int RXQ_FRAME_THR_EN_BIT = 5;
  localparam int RXQ_BYTE_THR_EN_BIT = 6;
  localparam int RXQ_DUR_THR_EN_BIT = 7;
  localparam int RXQ_IP_PAD_BIT = 9;
  localparam int RXQ_FRAME_THR_HIT_BIT = 10;
  localparam int RXQ_BYTE_THR_HIT_BIT = 11;
  localparam int RXQ_DUR_THR_HIT_BIT = 12;

  // cause vector order used between modules
  localparam int CAUSE_FRAME = 0;
  localparam int CAUSE_BYTE = 1;
  localparam int CAUSE_DUR = 2;

  // ----------------------------------------------------------------
  // reset values and widths
  // ----------------------------------------------------------------
  localparam logic [15:0] WORD_ZERO = 16'h0000;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam int SYNC_W = 33;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int DUR_UNIT_NS = 1000;
  localparam int DUR_UNIT_CYCLES = (DUR_UNIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [7:0] DUR_TICK_LAST = 8'(DUR_UNIT_CYCLES - 1);

endpackage

//--- hqc_sync.sv
// Purpose: two-flop synchroniser for host bus pins
// Assumes: inputs are quasi-static apart from the strobes
// Notes: strobes are fed active high so reset means idle
`timescale 1ns/10ps
module hqc_sync #(
  parameter int W = 1
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // data
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } hqc_sync_st_t;

  hqc_sync_st_t st_ff;
  hqc_sync_st_t nxt_st;

  always_comb
  begin
    nxt_st = st_ff;
    nxt_st.s1 = d;
    nxt_st.s2 = st_ff.s1;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      st_ff <= '0;
    else
      st_ff <= nxt_st;
  end

  assign q = st_ff.s2;

endmodule

//--- hqc_rx_thresh.sv
// Purpose: receive queue threshold and duration monitor
// Assumes: queue levels come from logic on the same clock
// Notes: duration counts whole units since the queue left empty
`timescale 1ns/10ps
module hqc_rx_thresh (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // enables, frame/byte/duration order
  input wire logic [2:0] thr_enable,
  // queue levels
  input wire logic [7:0] frame_count,
  input wire logic [13:0] byte_count,
  // thresholds
  input wire logic [7:0] frame_threshold_value,
  input wire logic [15:0] byte_threshold_value,
  input wire logic [15:0] duration_threshold_value,
  // results
  output logic [2:0] cause,
  output logic irq
);

  typedef struct packed {
    logic [7:0] tick;
    logic [15:0] dur;
    logic [2:0] cause;
    logic any;
    logic irq;
  } hqc_thr_st_t;

  hqc_thr_st_t st_ff;
  hqc_thr_st_t nxt_st;

  always_comb
  begin
    nxt_st = st_ff;
    nxt_st.irq = 1'b0;
    // timer runs only while a frame waits
    if (frame_count == 8'h00)
    begin
      nxt_st.tick = 8'h00;
      nxt_st.dur = 16'h0000;
    end
    else if (st_ff.tick == hqc_pkg::DUR_TICK_LAST)
    begin
      nxt_st.tick = 8'h00;
      if (st_ff.dur != 16'hffff)
        nxt_st.dur = st_ff.dur + 16'h0001;
    end
    else
      nxt_st.tick = st_ff.tick + 8'h01;
    nxt_st.cause[hqc_pkg::CAUSE_DUR] = thr_enable[hqc_pkg::CAUSE_DUR] &&
      (st_ff.dur > duration_threshold_value);
    nxt_st.cause[hqc_pkg::CAUSE_BYTE] = thr_enable[hqc_pkg::CAUSE_BYTE] &&
      ({2'b00, byte_count} > byte_threshold_value);
    nxt_st.cause[hqc_pkg::CAUSE_FRAME] = thr_enable[hqc_pkg::CAUSE_FRAME] &&
      (frame_count > frame_threshold_value);
    // any condition, raised once on entry
    nxt_st.any = |st_ff.cause;
    nxt_st.irq = (|st_ff.cause) && !st_ff.any;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      st_ff <= '0;
    else
      st_ff <= nxt_st;
  end

  assign cause = st_ff.cause;
  assign irq = st_ff.irq;

endmodule

//--- hqc_host_queue_command_control.sv
// Purpose: queue command and status registers behind the parallel host bus
// Assumes: queue engine, interrupt status and other registers live outside
// Notes: host pins pass two flops; accesses start on the synced strobe edge
//
// Summary of operation
// - byte count of head receive frame in 12 bits, upper bits zero.
// - byte count is shown per pending frame, zero when none waits.
// - space monitor bit raises tx space interrupt when free space suffices.
// - space monitor bit self clears after transmit; host waits for that.
// - writing one to manual enqueue queues the current transmit frame.
// - manual enqueue bit self clears on transmit done; host waits.
// - status bits 12..10 show duration, byte and frame threshold causes.
// - cause bits update when host writes one to interrupt bit 13.
// - bit 9 adds two pad bytes before each receive frame header.
// - bit 7 enables interrupt when queue age exceeds duration threshold.
// - bit 6 enables interrupt when queued bytes exceed byte threshold.
// - bit 5 enables interrupt when queued frames exceed frame threshold.
// - bit 4 advances receive read pointer after a frame is fully read.
// - bit 3 lets strobes with command pin low access queue data.
// - while queue access is on, only the receive command register answers.
// - writing one to bit 0 releases an errored frame, then self clears.
`timescale 1ns/10ps
module hqc_host_queue_command_control (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // host bus pins
  input wire logic chip_select_n,
  input wire logic read_strobe_n,
  input wire logic write_strobe_n,
  input wire logic cmd_select,
  input wire logic [10:0] host_addr,
  input wire logic [1:0] host_be,
  input wire logic [15:0] host_wdata,
  output logic [15:0] host_rdata,
  output logic host_rdata_oe,
  // receive queue status
  input wire logic [7:0] received_frame_count,
  input wire logic [11:0] received_byte_size,
  input wire logic [13:0] rxq_bytes_held,
  input wire logic rx_frame_fully_read,
  input wire logic rx_release_done,
  input wire logic [15:0] rxq_rd_data,
  // transmit queue status
  input wire logic [12:0] tx_free_space,
  input wire logic [12:0] next_tx_frame_size,
  input wire logic tx_frame_done,
  // thresholds and interrupt status register
  input wire logic [7:0] frame_threshold_value,
  input wire logic [15:0] byte_threshold_value,
  input wire logic [15:0] duration_threshold_value,
  input wire logic isr_rx_ack,
  // other registers
  input wire logic [15:0] ext_reg_rdata,
  // queue commands
  output logic tx_enqueue_req,
  output logic tx_space_irq,
  output logic rx_release_req,
  output logic rx_dequeue_req,
  output logic rx_threshold_irq,
  output logic ip_align_pad_enable,
  output logic dma_active,
  // queue data
  output logic rxq_rd_req,
  output logic txq_wr_req,
  output logic [15:0] txq_wr_data,
  output logic [1:0] txq_wr_be,
  // other register access
  output logic ext_reg_rd,
  output logic ext_reg_wr,
  output logic [10:0] ext_reg_addr,
  output logic [15:0] ext_reg_wdata,
  output logic [1:0] ext_reg_be
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic prev_rd;
    logic prev_wr;
    logic ext_pend;
    logic tx_space_monitor;
    logic tx_space_fired;
    logic manual_tx_enqueue;
    logic ip_align_pad_enable;
    logic duration_threshold_enable;
    logic byte_threshold_enable;
    logic frame_threshold_enable;
    logic auto_dequeue_enable;
    logic dma_access;
    logic release_error_frame;
    logic duration_threshold_hit;
    logic byte_threshold_hit;
    logic frame_threshold_hit;
    logic [7:0] hi_snap;
    logic [15:0] rdata;
    logic rdata_oe;
    logic tx_enqueue_req;
    logic tx_space_irq;
    logic rx_release_req;
    logic rx_dequeue_req;
    logic rx_threshold_irq;
    logic rxq_rd_req;
    logic txq_wr_req;
    logic [15:0] txq_wr_data;
    logic [1:0] txq_wr_be;
    logic ext_rd;
    logic ext_wr;
    logic [10:0] ext_addr;
    logic [15:0] ext_wdata;
    logic [1:0] ext_be;
  } hqc_st_t;

  hqc_st_t st_ff;
  hqc_st_t nxt_st;

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic [hqc_pkg::SYNC_W-1:0] pins_raw;
  logic [hqc_pkg::SYNC_W-1:0] pins_sync;
  logic s_cs;
  logic s_rd;
  logic s_wr;
  logic s_cmd;
  logic [10:0] s_addr;
  logic [1:0] s_be;
  logic [15:0] s_wdata;

  // strobes inverted ahead of the flops so reset reads as idle
  assign pins_raw = {~chip_select_n, ~read_strobe_n, ~write_strobe_n, cmd_select,
                     host_addr, host_be, host_wdata};

  hqc_sync #(
    .W(hqc_pkg::SYNC_W)
  ) u_sync (
    .clk(clk),
    .rst_n(rst_n),
    .d(pins_raw),
    .q(pins_sync)
  );

  assign {s_cs, s_rd, s_wr, s_cmd, s_addr, s_be, s_wdata} = pins_sync;

  // ----------------------------------------------------------------
  // threshold monitor
  // ----------------------------------------------------------------
  logic [2:0] thr_enable;
  logic [2:0] thr_cause;
  logic thr_irq;

  assign thr_enable = {st_ff.duration_threshold_enable, st_ff.byte_threshold_enable,
                       st_ff.frame_threshold_enable};

  hqc_rx_thresh u_thresh (
    .clk(clk),
    .rst_n(rst_n),
    .thr_enable(thr_enable),
    .frame_count(received_frame_count),
    .byte_count(rxq_bytes_held),
    .frame_threshold_value(frame_threshold_value),
    .byte_threshold_value(byte_threshold_value),
    .duration_threshold_value(duration_threshold_value),
    .cause(thr_cause),
    .irq(thr_irq)
  );

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [10:0] word_of(input logic [10:0] a);
    word_of = {a[10:1], 1'b0};
  endfunction

  function automatic logic [15:0] lane_merge(input logic [15:0] old,
                                             input logic [15:0] wd,
                                             input logic [1:0] be);
    lane_merge = {be[1] ? wd[15:8] : old[15:8], be[0] ? wd[7:0] : old[7:0]};
  endfunction

  // ----------------------------------------------------------------
  // register views
  // ----------------------------------------------------------------
  logic [15:0] byte_count_word;
  logic [15:0] txq_word;
  logic [15:0] rxq_word;

  always_comb
  begin
    // count only while a frame is pending
    byte_count_word = hqc_pkg::WORD_ZERO;
    if (received_frame_count != 8'h00)
      byte_count_word[hqc_pkg::BYTE_COUNT_W-1:0] = received_byte_size;
    txq_word = hqc_pkg::WORD_ZERO;
    txq_word[hqc_pkg::TXQ_MANUAL_ENQUEUE_BIT] = st_ff.manual_tx_enqueue;
    txq_word[hqc_pkg::TXQ_SPACE_MONITOR_BIT] = st_ff.tx_space_monitor;
    rxq_word = hqc_pkg::WORD_ZERO;
    rxq_word[hqc_pkg::RXQ_DUR_THR_HIT_BIT] = st_ff.duration_threshold_hit;
    rxq_word[hqc_pkg::RXQ_BYTE_THR_HIT_BIT] = st_ff.byte_threshold_hit;
    rxq_word[hqc_pkg::RXQ_FRAME_THR_HIT_BIT] = st_ff.frame_threshold_hit;
    rxq_word[hqc_pkg::RXQ_IP_PAD_BIT] = st_ff.ip_align_pad_enable;
    rxq_word[hqc_pkg::RXQ_DUR_THR_EN_BIT] = st_ff.duration_threshold_enable;
    rxq_word[hqc_pkg::RXQ_BYTE_THR_EN_BIT] = st_ff.byte_threshold_enable;
    rxq_word[hqc_pkg::RXQ_FRAME_THR_EN_BIT] = st_ff.frame_threshold_enable;
    rxq_word[hqc_pkg::RXQ_AUTO_DEQUEUE_BIT] = st_ff.auto_dequeue_enable;
    rxq_word[hqc_pkg::RXQ_DMA_ACCESS_BIT] = st_ff.dma_access;
    rxq_word[hqc_pkg::RXQ_RELEASE_ERROR_BIT] = st_ff.release_error_frame;
  end

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  logic rd_act;
  logic wr_act;
  logic rd_go;
  logic wr_go;
  logic [10:0] word_addr;
  logic blocked;
  logic [15:0] rxq_new;

  always_comb
  begin
    rxq_new = lane_merge(rxq_word, s_wdata, s_be);
    nxt_st = st_ff;
    nxt_st.tx_enqueue_req = 1'b0;
    nxt_st.tx_space_irq = 1'b0;
    nxt_st.rx_release_req = 1'b0;
    nxt_st.rx_dequeue_req = 1'b0;
    nxt_st.rxq_rd_req = 1'b0;
    nxt_st.txq_wr_req = 1'b0;
    nxt_st.ext_rd = 1'b0;
    nxt_st.ext_wr = 1'b0;
    nxt_st.ext_pend = 1'b0;
    rd_act = s_cs && s_rd;
    wr_act = s_cs && s_wr;
    rd_go = rd_act && !st_ff.prev_rd;
    wr_go = wr_act && !st_ff.prev_wr;
    nxt_st.prev_rd = rd_act;
    nxt_st.prev_wr = wr_act;
    nxt_st.rdata_oe = rd_act;
    word_addr = word_of(s_addr);
    // only the receive command register stays open
    blocked = st_ff.dma_access && (word_addr != hqc_pkg::RX_QUEUE_COMMAND_OFF);

    // other registers answer one cycle after the strobe
    if (st_ff.ext_pend)
      nxt_st.rdata = ext_reg_rdata;

    if (tx_frame_done)
    begin
      nxt_st.tx_space_monitor = 1'b0;
      nxt_st.tx_space_fired = 1'b0;
      nxt_st.manual_tx_enqueue = 1'b0;
    end
    if (rx_release_done)
      nxt_st.release_error_frame = 1'b0;
    if (isr_rx_ack)
    begin
      nxt_st.duration_threshold_hit = thr_cause[hqc_pkg::CAUSE_DUR];
      nxt_st.byte_threshold_hit = thr_cause[hqc_pkg::CAUSE_BYTE];
      nxt_st.frame_threshold_hit = thr_cause[hqc_pkg::CAUSE_FRAME];
    end
    nxt_st.rx_threshold_irq = thr_irq;
    // space monitor fires once per arming
    if (st_ff.tx_space_monitor && !st_ff.tx_space_fired &&
        (tx_free_space >= next_tx_frame_size))
    begin
      nxt_st.tx_space_irq = 1'b1;
      nxt_st.tx_space_fired = 1'b1;
    end
    if (st_ff.auto_dequeue_enable && rx_frame_fully_read)
      nxt_st.rx_dequeue_req = 1'b1;

    if (rd_go)
    begin
      nxt_st.rdata = hqc_pkg::WORD_ZERO;
      if (!s_cmd)
      begin
        if (st_ff.dma_access)
        begin
          nxt_st.rxq_rd_req = 1'b1;
          nxt_st.rdata = rxq_rd_data;
        end
      end
      else if (!blocked)
      begin
        case (word_addr)
          hqc_pkg::RX_FRAME_BYTE_COUNT_OFF:
          begin
            // low byte read freezes the high byte
            if (s_be == 2'b10)
              nxt_st.rdata = {st_ff.hi_snap, hqc_pkg::BYTE_ZERO};
            else
              nxt_st.rdata = byte_count_word;
            if (s_be[0])
              nxt_st.hi_snap = byte_count_word[15:8];
          end
          hqc_pkg::TX_QUEUE_COMMAND_OFF:
            nxt_st.rdata = txq_word;
          hqc_pkg::RX_QUEUE_COMMAND_OFF:
            nxt_st.rdata = rxq_word;
          default:
          begin
            nxt_st.ext_rd = 1'b1;
            nxt_st.ext_pend = 1'b1;
            nxt_st.ext_addr = s_addr;
            nxt_st.ext_be = s_be;
          end
        endcase
      end
    end

    // writes come last so a space monitor set beats a same-cycle self clear
    if (wr_go)
    begin
      if (!s_cmd)
      begin
        if (st_ff.dma_access)
        begin
          nxt_st.txq_wr_req = 1'b1;
          nxt_st.txq_wr_data = s_wdata;
          nxt_st.txq_wr_be = s_be;
        end
      end
      else if (!blocked)
      begin
        case (word_addr)
          hqc_pkg::RX_FRAME_BYTE_COUNT_OFF:
            nxt_st.rdata = st_ff.rdata;
          hqc_pkg::TX_QUEUE_COMMAND_OFF:
          begin
            if (s_be[0])
            begin
              if (s_wdata[hqc_pkg::TXQ_SPACE_MONITOR_BIT])
              begin
                nxt_st.tx_space_monitor = 1'b1;
                nxt_st.tx_space_fired = 1'b0;
              end
              if (s_wdata[hqc_pkg::TXQ_MANUAL_ENQUEUE_BIT] && !st_ff.manual_tx_enqueue)
              begin
                nxt_st.manual_tx_enqueue = 1'b1;
                nxt_st.tx_enqueue_req = 1'b1;
              end
            end
          end
          hqc_pkg::RX_QUEUE_COMMAND_OFF:
          begin
            // pad enable stored for the receive path
            nxt_st.ip_align_pad_enable = rxq_new[hqc_pkg::RXQ_IP_PAD_BIT];
            nxt_st.duration_threshold_enable = rxq_new[hqc_pkg::RXQ_DUR_THR_EN_BIT];
            nxt_st.byte_threshold_enable = rxq_new[hqc_pkg::RXQ_BYTE_THR_EN_BIT];
            nxt_st.frame_threshold_enable = rxq_new[hqc_pkg::RXQ_FRAME_THR_EN_BIT];
            nxt_st.auto_dequeue_enable = rxq_new[hqc_pkg::RXQ_AUTO_DEQUEUE_BIT];
            nxt_st.dma_access = rxq_new[hqc_pkg::RXQ_DMA_ACCESS_BIT];
            if (s_be[0] && s_wdata[hqc_pkg::RXQ_RELEASE_ERROR_BIT] &&
                !st_ff.release_error_frame)
            begin
              nxt_st.release_error_frame = 1'b1;
              nxt_st.rx_release_req = 1'b1;
            end
          end
          default:
          begin
            nxt_st.ext_wr = 1'b1;
            nxt_st.ext_addr = s_addr;
            nxt_st.ext_wdata = s_wdata;
            nxt_st.ext_be = s_be;
          end
        endcase
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      st_ff <= '0;
    else
      st_ff <= nxt_st;
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign host_rdata = st_ff.rdata;
  assign host_rdata_oe = st_ff.rdata_oe;
  assign tx_enqueue_req = st_ff.tx_enqueue_req;
  assign tx_space_irq = st_ff.tx_space_irq;
  assign rx_release_req = st_ff.rx_release_req;
  assign rx_dequeue_req = st_ff.rx_dequeue_req;
  assign rx_threshold_irq = st_ff.rx_threshold_irq;
  assign ip_align_pad_enable = st_ff.ip_align_pad_enable;
  assign dma_active = st_ff.dma_access;
  assign rxq_rd_req = st_ff.rxq_rd_req;
  assign txq_wr_req = st_ff.txq_wr_req;
  assign txq_wr_data = st_ff.txq_wr_data;
  assign txq_wr_be = st_ff.txq_wr_be;
  assign ext_reg_rd = st_ff.ext_rd;
  assign ext_reg_wr = st_ff.ext_wr;
  assign ext_reg_addr = st_ff.ext_addr;
  assign ext_reg_wdata = st_ff.ext_wdata;
  assign ext_reg_be = st_ff.ext_be;

endmodule

//--- hqc_properties.sv
// Purpose: port checks of the queue command block
// Assumes: host strobes stay low five clocks or more
// Notes: bound to every instance of the top module
`timescale 1ns/10ps
module hqc_chk (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // watched signals
  input wire logic write_strobe_n,
  input wire logic [12:0] tx_free_space,
  input wire logic [12:0] next_tx_frame_size,
  input wire logic rx_frame_fully_read,
  input wire logic tx_enqueue_req,
  input wire logic tx_space_irq,
  input wire logic rx_release_req,
  input wire logic rx_dequeue_req,
  input wire logic rx_threshold_irq,
  input wire logic ip_align_pad_enable,
  input wire logic dma_active,
  input wire logic rxq_rd_req,
  input wire logic txq_wr_req,
  input wire logic ext_reg_rd,
  input wire logic ext_reg_wr
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  property p_dma_block;
    dma_active |-> !ext_reg_rd && !ext_reg_wr;
  endproperty
  a_dma_block: assert property (p_dma_block) else $error("ext access in dma");
  property p_enq_once;
    tx_enqueue_req |=> !tx_enqueue_req [*3];
  endproperty
  a_enq_once: assert property (p_enq_once) else $error("enqueue repeated");
  property p_rel_once;
    rx_release_req |=> !rx_release_req [*3];
  endproperty
  a_rel_once: assert property (p_rel_once) else $error("release repeated");
  property p_deq;
    rx_dequeue_req |-> $past(rx_frame_fully_read);
  endproperty
  a_deq: assert property (p_deq) else $error("dequeue without read");
  property p_space;
    tx_space_irq |-> $past(tx_free_space) >= $past(next_tx_frame_size);
  endproperty
  a_space: assert property (p_space) else $error("space irq early");
  property p_queue;
    rxq_rd_req || txq_wr_req |-> dma_active;
  endproperty
  a_queue: assert property (p_queue) else $error("queue access no dma");
  property p_cmd_bits;
    $changed(ip_align_pad_enable) || $changed(dma_active) |-> !$past(write_strobe_n, 2);
  endproperty
  a_cmd_bits: assert property (p_cmd_bits) else $error("cmd bit moved");
  property p_irq;
    rx_threshold_irq |=> !rx_threshold_irq;
  endproperty
  a_irq: assert property (p_irq) else $error("irq not a pulse");
endmodule
bind hqc_host_queue_command_control hqc_chk u_chk (.clk, .rst_n, .write_strobe_n,
  .tx_free_space, .next_tx_frame_size, .rx_frame_fully_read, .tx_enqueue_req,
  .tx_space_irq, .rx_release_req, .rx_dequeue_req, .rx_threshold_irq,
  .ip_align_pad_enable, .dma_active, .rxq_rd_req, .txq_wr_req, .ext_reg_rd, .ext_reg_wr);

//--- hqc_host_model.sv
// Purpose: host processor on the parallel bus
// Assumes: no ready pin, fixed strobe timing
// Notes: released data lines show the inverse value
`timescale 1ns/10ps
module hqc_host_model (
  // clock
  input wire logic clk,
  // host pins
  output logic chip_select_n,
  output logic read_strobe_n,
  output logic write_strobe_n,
  output logic cmd_select,
  output logic [10:0] host_addr,
  output logic [1:0] host_be,
  output logic [15:0] host_wdata,
  input wire logic [15:0] host_rdata
);
  initial
  begin
    {chip_select_n, read_strobe_n, write_strobe_n, cmd_select} = 4'hf;
    host_addr = 11'h000;
    host_be = 2'h0;
    host_wdata = 16'h0000;
  end
  // low six clocks covers sync plus ext latency
  task automatic acc(input logic w, input logic c, input logic [10:0] a,
                     input logic [1:0] be, input logic [15:0] d, output logic [15:0] r);
    @(posedge clk);
    chip_select_n <= 1'b0;
    read_strobe_n <= w;
    write_strobe_n <= !w;
    cmd_select <= c;
    host_addr <= a;
    host_be <= be;
    host_wdata <= d;
    repeat (5) @(posedge clk);
    @(negedge clk);
    r = host_rdata;
    @(posedge clk);
    {chip_select_n, read_strobe_n, write_strobe_n} <= 3'h7;
    host_wdata <= ~d;
    repeat (4) @(posedge clk);
  endtask
  task automatic rd8(input logic [10:0] a, output logic [15:0] r);
    logic [15:0] lo;
    acc(1'b0, 1'b1, a, 2'b01, 16'h0000, lo);
    acc(1'b0, 1'b1, a, 2'b10, 16'h0000, r);
    r[7:0] = lo[7:0];
  endtask
endmodule

//--- tb.sv
// Purpose: self-checking bench of the queue command block
// Assumes: queue engine side driven by the bench
// Notes: pulse counts kept by one monitor block
`timescale 1ns/10ps
module tb;
  localparam logic [10:0] CNT = hqc_pkg::RX_FRAME_BYTE_COUNT_OFF;
  localparam logic [10:0] TXC = hqc_pkg::TX_QUEUE_COMMAND_OFF;
  localparam logic [10:0] RXC = hqc_pkg::RX_QUEUE_COMMAND_OFF;
  logic clk = 1'b0, rst_n = 1'b0;
  logic chip_select_n, read_strobe_n, write_strobe_n, cmd_select;
  logic [10:0] host_addr, ext_reg_addr;
  logic [1:0] host_be, txq_wr_be, ext_reg_be;
  logic [15:0] host_wdata, host_rdata, txq_wr_data, ext_reg_wdata, rv;
  logic [7:0] received_frame_count = 8'h00, frame_threshold_value = 8'hff;
  logic [11:0] received_byte_size = 12'h000;
  logic [13:0] rxq_bytes_held = 14'h0000;
  logic [12:0] tx_free_space = 13'h0000, next_tx_frame_size = 13'h0000;
  logic [15:0] rxq_rd_data = 16'h0000, ext_reg_rdata = 16'hbeef;
  logic [15:0] byte_threshold_value = 16'hffff, duration_threshold_value = 16'hffff;
  logic rx_frame_fully_read = 1'b0, rx_release_done = 1'b0, tx_frame_done = 1'b0;
  logic isr_rx_ack = 1'b0;
  logic host_rdata_oe, tx_enqueue_req, tx_space_irq, rx_release_req, rx_dequeue_req;
  logic rx_threshold_irq, ip_align_pad_enable, dma_active, rxq_rd_req, txq_wr_req;
  logic ext_reg_rd, ext_reg_wr;
  int err_total = 0, cmp_count = 0;
  int n_enq = 0, n_spc = 0, n_rel = 0, n_deq = 0, n_irq = 0, n_erd = 0;
  hqc_host_queue_command_control uut (.*);
  hqc_host_model host (.clk, .chip_select_n, .read_strobe_n, .write_strobe_n, .cmd_select,
    .host_addr, .host_be, .host_wdata, .host_rdata);
  always #5 clk = ~clk;
  always @(posedge clk)
  begin
    n_enq <= n_enq + tx_enqueue_req;
    n_spc <= n_spc + tx_space_irq;
    n_rel <= n_rel + rx_release_req;
    n_deq <= n_deq + rx_dequeue_req;
    n_irq <= n_irq + rx_threshold_irq;
    n_erd <= n_erd + ext_reg_rd;
  end
  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wr(input logic [10:0] a, input logic [15:0] d);
    host.acc(1'b1, 1'b1, a, 2'b11, d, rv);
  endtask
  task automatic rdc(input string nm, input logic [10:0] a, input logic [15:0] e);
    host.acc(1'b0, 1'b1, a, 2'b11, 16'h0000, rv);
    chk(nm, rv, e);
  endtask
  task automatic ack;
    @(posedge clk);
    isr_rx_ack <= 1'b1;
    @(posedge clk);
    isr_rx_ack <= 1'b0;
  endtask
  task automatic results;
    $display("compares %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic t_count;
    rdc("rxc rst", RXC, 16'h0000);
    rdc("txc rst", TXC, 16'h0000);
    rdc("cnt none", CNT, 16'h0000);
    @(posedge clk);
    received_frame_count <= 8'h02;
    received_byte_size <= 12'habc;
    rdc("cnt", CNT, 16'h0abc);
    host.rd8(CNT, rv);
    chk("cnt8", rv, 16'h0abc);
    rdc("cnt again", CNT, 16'h0abc);
    $display("test count done");
  endtask
  task automatic t_tx;
    tx_free_space <= 13'h0010;
    next_tx_frame_size <= 13'h0020;
    wr(TXC, 16'h0003);
    rdc("txc set", TXC, 16'h0003);
    chk("spc early", 16'(n_spc), 16'h0000);
    tx_free_space <= 13'h0020;
    for (int i = 0; i < 20 && n_spc == 0; i++)
      @(posedge clk);
    if (n_spc == 0)
    begin
      err_total++;
      results();
    end
    chk("spc", 16'(n_spc), 16'h0001);
    chk("enq", 16'(n_enq), 16'h0001);
    tx_frame_done <= 1'b1;
    @(posedge clk);
    tx_frame_done <= 1'b0;
    rdc("txc clr", TXC, 16'h0000);
    $display("test tx done");
  endtask
  task automatic t_rx;
    frame_threshold_value <= 8'h01;
    wr(RXC, 16'hfff6);
    rdc("rxc rw", RXC, 16'h02f0);
    chk("pad", 16'(ip_align_pad_enable), 16'h0001);
    ack();
    rdc("frame hit", RXC, 16'h06f0);
    rxq_bytes_held <= 14'h0011;
    byte_threshold_value <= 16'h0010;
    ack();
    rdc("byte hit", RXC, 16'h0ef0);
    duration_threshold_value <= 16'h0001;
    repeat (300) @(posedge clk);
    ack();
    rdc("dur hit", RXC, 16'h1ef0);
    chk("irq", 16'(n_irq), 16'h0001);
    rx_frame_fully_read <= 1'b1;
    @(posedge clk);
    rx_frame_fully_read <= 1'b0;
    repeat (3) @(posedge clk);
    chk("deq", 16'(n_deq), 16'h0001);
    wr(RXC, 16'h02f1);
    rdc("rel set", RXC, 16'h1ef1);
    chk("rel", 16'(n_rel), 16'h0001);
    rx_release_done <= 1'b1;
    @(posedge clk);
    rx_release_done <= 1'b0;
    rdc("rel clr", RXC, 16'h1ef0);
    $display("test rx done");
  endtask
  task automatic t_dma;
    wr(11'h186, 16'h0000);
    chk("ext addr", {5'h00, ext_reg_addr}, 16'h0186);
    wr(RXC, 16'h0008);
    chk("dma", 16'(dma_active), 16'h0001);
    rdc("blocked", 11'h184, 16'h0000);
    chk("ext rd", 16'(n_erd), 16'h0000);
    rxq_rd_data <= 16'h5a3c;
    host.acc(1'b0, 1'b0, 11'h000, 2'b11, 16'h0000, rv);
    chk("rxq", rv, 16'h5a3c);
    host.acc(1'b1, 1'b0, 11'h000, 2'b11, 16'h1234, rv);
    chk("txq", txq_wr_data, 16'h1234);
    chk("txq be", {14'h0000, txq_wr_be}, 16'h0003);
    rdc("rxc dma", RXC, 16'h1c08);
    wr(RXC, 16'h0000);
    rdc("ext", 11'h184, 16'hbeef);
    chk("ext rd", 16'(n_erd), 16'h0001);
    $display("test dma done");
  endtask
  initial
  begin
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    t_count();
    t_tx();
    t_rx();
    t_dma();
    results();
  end
endmodule
